// ### pkg/servo_ctrl_regs.vh
`ifndef SERVO_CTRL_REGS_VH
`define SERVO_CTRL_REGS_VH
// apb byte offsets
`define OFS_CTRL 8'h00
`define OFS_CONST1 8'h04
`define OFS_CONST2 8'h08
`define OFS_SCALE 8'h0c
`define OFS_RATED_I 8'h10
`define OFS_ACCEL 8'h14
`define OFS_DECEL 8'h18
`define OFS_KP 8'h1c
`define OFS_TN 8'h20
`define OFS_SERIAL_SP 8'h24
`define OFS_OV_LIMIT 8'h28
`define OFS_I2T_LIMIT 8'h2c
`define OFS_STATUS 8'h30
`define OFS_SPEED_RB 8'h34
`define OFS_PEAK_I 8'h38
// control register fields
`define CTRL_MODE_LSB 0
`define CTRL_SRC_LSB 2
`define CTRL_RAMP_LSB 4
`define CTRL_POL_BIT 6
`define CTRL_SAVE_BIT 7
// operating modes
`define MODE_CURRENT 2'h0
`define MODE_SPEED 2'h1
`define MODE_POSITION 2'h2
// setpoint sources
`define SRC_ANALOGUE 2'h0
`define SRC_SERIAL 2'h1
`define SRC_CONST 2'h2
// ramp profile types
`define RAMP_OFF 2'h0
`define RAMP_LINEAR 2'h1
`define RAMP_SIN2 2'h2
// reset values and kp limit
`define RST_CTRL 8'h11
`define RST_SCALE 16'h0bb8
`define RST_RATED_I 16'h0400
`define RST_PEAK_I 16'h0c00
`define RST_ACCEL 16'h0064
`define RST_OV_LIMIT 16'h0ffc
`define RST_I2T_LIMIT 32'h00100000
`define KP_MAX 14'h270f
// timing and other constants
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_US 1000
`define BLINK_SLOT_MS 250
`define OT_LIMIT_C 8'h55
`define SIN2_INC_MUL 15'h53e3
`endif

// ### hw/servo_setpoint_ramp_fault_control.v
`timescale 1ns/100ps
`include "servo_ctrl_regs.vh"
module servo_setpoint_ramp_fault_control #(
    parameter TICK_CYCLES = `TICK_PERIOD_US * 1000 / `CLK_PERIOD_NS,
    parameter BLINK_CYCLES = `BLINK_SLOT_MS * 1000000 / `CLK_PERIOD_NS
) (
    input wire pclk, // control clock
    input wire presetn, // async reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction
    input wire [7:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output reg [31:0] prdata, // apb read data
    output reg pready, // apb ready
    output reg pslverr, // apb error, unmapped
    input wire enable_input, // control enable pin
    input wire constant_select_input, // constant select pin
    input wire [9:0] analogue_setpoint_input, // signed adc word
    input wire phase_short, // short between phases
    input wire [15:0] dc_link_level, // dc-link voltage word
    input wire [7:0] stage_temp_c, // stage temperature
    input wire [2:0] angle_state, // angle sensor lines
    input wire [15:0] motor_current_mag, // |phase current|
    output reg power_stage_on, // stage enabled
    output reg led_red, // red status led
    output reg signed [31:0] speed_setpoint_out, // 0.01 rpm
    output reg signed [17:0] current_setpoint_out, // current
    output reg [15:0] current_limit_out, // active limit
    output reg [13:0] kp_out, // speed loop gain
    output reg [15:0] tn_out, // speed loop reset time
    output reg save_pulse_out // copy to nvm request
);
    // software registers
    reg [7:0] ctrl_r;
    reg [15:0] const1_r, const2_r, serial_sp_r;
    reg [15:0] scale_r, rated_i_r, peak_i_r;
    reg [15:0] accel_r, decel_r, ov_limit_r;
    reg [31:0] i2t_limit_r;
    reg [39:0] i2t_acc_r; // i2t heat accumulator
    reg i2t_over_r; // overload time used up, shown in status
    // two-flop synchronisers, stage one read only by stage two
    reg [23:0] sync1_r, sync2_r;
    reg [31:0] wsync1_r, wsync2_r;
    wire en_s = sync2_r[0];
    wire csel_s = sync2_r[1];
    wire short_s = sync2_r[2];
    wire [2:0] angle_s = sync2_r[5:3];
    wire [9:0] ain_s = sync2_r[15:6];
    wire [7:0] temp_s = sync2_r[23:16];
    wire [15:0] dc_s = wsync2_r[15:0];
    wire [15:0] imag_s = wsync2_r[31:16];

    // adc words are assumed to hold still across the two stages
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 24'h0;
            sync2_r <= 24'h0;
            wsync1_r <= 32'h0;
            wsync2_r <= 32'h0;
        end else begin
            sync1_r <= {stage_temp_c, analogue_setpoint_input,
                angle_state, phase_short, constant_select_input,
                enable_input};
            sync2_r <= sync1_r;
            wsync1_r <= {motor_current_mag, dc_link_level};
            wsync2_r <= wsync1_r;
        end
    end

    wire [1:0] mode = ctrl_r[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
    wire [1:0] src_sel = ctrl_r[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
    wire [1:0] ramp_sel = ctrl_r[`CTRL_RAMP_LSB+1:`CTRL_RAMP_LSB];
    wire pol_neg = ctrl_r[`CTRL_POL_BIT];

    // fault causes, live
    wire [3:0] cause;
    assign cause[0] = short_s;
    assign cause[1] = dc_s > ov_limit_r;
    assign cause[2] = temp_s > `OT_LIMIT_C;
    assign cause[3] = (angle_s == 3'h0) || (angle_s == 3'h7);
    reg [3:0] faults_r; // latched faults

    // latch faults; enable low acknowledges, but a live cause wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            faults_r <= 4'h0;
        end else begin
            faults_r <= cause | (faults_r & {4{en_s}});
        end
    end

    // stage on only with enable and no latched or live fault
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_stage_on <= 1'b0;
        end else begin
            power_stage_on <= en_s && !(|faults_r) && !(|cause);
        end
    end

    // apb slave, one wait state so read data comes from a flop
    wire acc = psel && penable;
    wire wr_now = acc && pwrite && pready;
    reg [31:0] rd_v;
    reg hit_v;
    always @* begin
        hit_v = 1'b1;
        rd_v = 32'h0;
        case (paddr)
            `OFS_CTRL: rd_v = {24'h0, 1'b0, ctrl_r[6:0]};
            `OFS_CONST1: rd_v = {16'h0, const1_r};
            `OFS_CONST2: rd_v = {16'h0, const2_r};
            `OFS_SCALE: rd_v = {16'h0, scale_r};
            `OFS_RATED_I: rd_v = {16'h0, rated_i_r};
            `OFS_ACCEL: rd_v = {16'h0, accel_r};
            `OFS_DECEL: rd_v = {16'h0, decel_r};
            `OFS_KP: rd_v = {18'h0, kp_out};
            `OFS_TN: rd_v = {16'h0, tn_out};
            `OFS_SERIAL_SP: rd_v = {16'h0, serial_sp_r};
            `OFS_OV_LIMIT: rd_v = {16'h0, ov_limit_r};
            `OFS_I2T_LIMIT: rd_v = i2t_limit_r;
            `OFS_STATUS: rd_v = {24'h0, i2t_over_r, power_stage_on,
                en_s, 1'b0, faults_r};
            `OFS_SPEED_RB: rd_v = speed_setpoint_out;
            `OFS_PEAK_I: rd_v = {16'h0, peak_i_r};
            default: hit_v = 1'b0; // unmapped
        endcase
    end

    // bus handshake and readback
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc && !pready;
            pslverr <= acc && !pready && !hit_v;
            prdata <= (acc && !pready && !pwrite) ? rd_v : 32'h0;
        end
    end

    // register writes take effect at once in the datapath
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `RST_CTRL;
            const1_r <= 16'h0;
            const2_r <= 16'h0;
            serial_sp_r <= 16'h0;
            scale_r <= `RST_SCALE;
            rated_i_r <= `RST_RATED_I;
            peak_i_r <= `RST_PEAK_I;
            accel_r <= `RST_ACCEL;
            decel_r <= `RST_ACCEL;
            ov_limit_r <= `RST_OV_LIMIT;
            i2t_limit_r <= `RST_I2T_LIMIT;
            kp_out <= 14'h0;
            tn_out <= 16'h0;
            save_pulse_out <= 1'b0;
        end else begin
            save_pulse_out <= 1'b0;
            if (wr_now) begin
                case (paddr)
                    `OFS_CTRL: begin
                        ctrl_r <= {1'b0, pwdata[6:0]};
                        save_pulse_out <= pwdata[`CTRL_SAVE_BIT];
                    end
                    `OFS_CONST1: const1_r <= pwdata[15:0];
                    `OFS_CONST2: const2_r <= pwdata[15:0];
                    `OFS_SCALE: scale_r <= pwdata[15:0];
                    `OFS_RATED_I: rated_i_r <= pwdata[15:0];
                    `OFS_ACCEL: accel_r <= pwdata[15:0];
                    `OFS_DECEL: decel_r <= pwdata[15:0];
                    `OFS_KP: begin
                        // out-of-range gain is refused, old value kept
                        if (pwdata[31:14] == 18'h0 &&
                            pwdata[13:0] <= `KP_MAX)
                            kp_out <= pwdata[13:0];
                    end
                    `OFS_TN: tn_out <= pwdata[15:0];
                    `OFS_SERIAL_SP: serial_sp_r <= pwdata[15:0];
                    `OFS_OV_LIMIT: ov_limit_r <= pwdata[15:0];
                    `OFS_I2T_LIMIT: i2t_limit_r <= pwdata;
                    `OFS_PEAK_I: peak_i_r <= pwdata[15:0];
                    default: save_pulse_out <= 1'b0;
                endcase
            end
        end
    end

    // control tick
    reg [31:0] tick_cnt_r;
    wire tick = (tick_cnt_r == TICK_CYCLES - 1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
        end
    end

    // source select, q15 setpoint where 0x7fff is full scale
    reg signed [15:0] src_v;
    always @* begin
        case (src_sel)
            `SRC_ANALOGUE: src_v = {ain_s, 6'h00};
            `SRC_SERIAL: src_v = serial_sp_r;
            `SRC_CONST: src_v = csel_s ? const2_r : const1_r;
            default: src_v = 16'sh0;
        endcase
    end
    wire signed [15:0] src_p = pol_neg ? -src_v : src_v;
    wire signed [32:0] spd_prod = src_p * $signed({1'b0, scale_r});
    wire signed [17:0] tgt_rpm = spd_prod[32:15];
    wire signed [31:0] tgt_c = tgt_rpm * 32'sd100; // 0.01 rpm
    wire signed [32:0] cur_prod = src_p * $signed({1'b0, rated_i_r});
    wire signed [17:0] cur_v = cur_prod[32:15];

    // i2t accumulator, integrates i^2 - rated^2 per tick
    wire [31:0] isq = imag_s * imag_s;
    wire [31:0] rsq = rated_i_r * rated_i_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i2t_acc_r <= 40'h0;
            i2t_over_r <= 1'b0;
        end else begin
            if (tick) begin
                if (isq >= rsq)
                    i2t_acc_r <= (&i2t_acc_r[39:32]) ? i2t_acc_r :
                        i2t_acc_r + {8'h0, isq - rsq};
                else if (i2t_acc_r > {8'h0, rsq - isq})
                    i2t_acc_r <= i2t_acc_r - {8'h0, rsq - isq};
                else
                    i2t_acc_r <= 40'h0; // cooled down
            end
            i2t_over_r <= i2t_acc_r > {i2t_limit_r, 8'h00};
        end
    end
    wire [15:0] ilim = i2t_over_r ? rated_i_r : peak_i_r;
    wire signed [17:0] ilim_s = $signed({2'b00, ilim});

    // current path: unramped, clamped, zero when stage is off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_setpoint_out <= 18'sh0;
            current_limit_out <= 16'h0;
        end else begin
            current_limit_out <= ilim;
            if (!power_stage_on || mode != `MODE_CURRENT)
                current_setpoint_out <= 18'sh0;
            else if (cur_v > ilim_s)
                current_setpoint_out <= ilim_s;
            else if (cur_v < -ilim_s)
                current_setpoint_out <= -ilim_s;
            else
                current_setpoint_out <= cur_v;
        end
    end

    // effective ramp type; sin2 falls back to linear on analogue
    reg [1:0] rtype_v;
    always @* begin
        rtype_v = ramp_sel;
        if (rtype_v == `RAMP_SIN2 && src_sel == `SRC_ANALOGUE)
            rtype_v = `RAMP_LINEAR;
        if (rtype_v == `RAMP_OFF && mode == `MODE_POSITION)
            rtype_v = `RAMP_LINEAR;
        if (rtype_v == 2'h3)
            rtype_v = `RAMP_OFF;
    end

    // linear step: accel away from zero, decel towards it
    wire up = tgt_c > speed_setpoint_out;
    wire outward = up ? !speed_setpoint_out[31] :
        (speed_setpoint_out[31] || speed_setpoint_out == 32'sh0);
    wire signed [31:0] step = {16'h0, outward ? accel_r : decel_r};
    wire signed [31:0] diff = tgt_c - speed_setpoint_out;
    wire signed [31:0] lin_nxt = up ?
        ((diff > step) ? speed_setpoint_out + step : tgt_c) :
        ((-diff > step) ? speed_setpoint_out - step : tgt_c);

    // sin2 profile state; smoothstep approximates sin^2
    reg signed [31:0] s2_start_r, s2_end_r;
    reg [16:0] s2_phase_r; // q16, 0x10000 is done
    wire [30:0] s2_inc_w = accel_r * `SIN2_INC_MUL;
    wire [16:0] s2_inc = {1'b0, s2_inc_w[30:15]}; // 65536/100000
    wire [17:0] ph_sum = {1'b0, s2_phase_r} + {1'b0, s2_inc};
    wire [16:0] ph_nxt = ph_sum[17:16] != 2'h0 ? 17'h10000 :
        ph_sum[16:0];
    wire [33:0] x2w = ph_nxt * ph_nxt;
    wire [16:0] x2 = x2w[32:16];
    wire [33:0] x3w = x2 * ph_nxt;
    wire [16:0] x3 = x3w[32:16];
    wire [18:0] shape = 19'd3 * x2 - 19'd2 * x3; // 3x^2-2x^3
    wire signed [32:0] s2_delta = s2_end_r - s2_start_r;
    wire signed [52:0] s2_prod = s2_delta * $signed({1'b0, shape});
    wire signed [31:0] s2_nxt = s2_start_r + s2_prod[47:16];

    // speed ramp, advanced once per tick
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_setpoint_out <= 32'sh0;
            s2_start_r <= 32'sh0;
            s2_end_r <= 32'sh0;
            s2_phase_r <= 17'h10000;
        end else if (!power_stage_on || mode == `MODE_CURRENT) begin
            speed_setpoint_out <= 32'sh0;
            s2_start_r <= 32'sh0;
            s2_end_r <= 32'sh0;
            s2_phase_r <= 17'h10000;
        end else if (rtype_v == `RAMP_OFF) begin
            speed_setpoint_out <= tgt_c;
            s2_end_r <= tgt_c;
        end else if (rtype_v == `RAMP_SIN2 && tgt_c != s2_end_r) begin
            // new step restarts the profile from where we stand
            s2_start_r <= speed_setpoint_out;
            s2_end_r <= tgt_c;
            s2_phase_r <= 17'h0;
        end else if (tick) begin
            s2_end_r <= tgt_c;
            if (rtype_v == `RAMP_SIN2) begin
                speed_setpoint_out <= s2_nxt;
                s2_phase_r <= ph_nxt;
            end else begin
                speed_setpoint_out <= lin_nxt;
            end
        end
    end

    // blink code: n pulses for fault n, then a four-slot pause
    reg [31:0] slot_cnt_r;
    reg [4:0] blink_idx_r;
    reg [2:0] code_v;
    always @* begin
        code_v = 3'h0;
        if (faults_r[3])
            code_v = 3'h4;
        if (faults_r[2])
            code_v = 3'h3;
        if (faults_r[1])
            code_v = 3'h2;
        if (faults_r[0])
            code_v = 3'h1; // lowest set bit wins, only its code shown
    end
    wire [4:0] blink_len = {1'b0, code_v, 1'b0} + 5'h4;
    wire slot_end = (slot_cnt_r == BLINK_CYCLES - 1);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_cnt_r <= 32'h0;
            blink_idx_r <= 5'h0;
            led_red <= 1'b0;
        end else begin
            slot_cnt_r <= slot_end ? 32'h0 : slot_cnt_r + 32'h1;
            if (code_v == 3'h0)
                blink_idx_r <= 5'h0;
            else if (slot_end)
                blink_idx_r <= (blink_idx_r >= blink_len - 5'h1) ?
                    5'h0 : blink_idx_r + 5'h1;
            led_red <= (code_v != 3'h0) && !blink_idx_r[0] &&
                (blink_idx_r < {1'b0, code_v, 1'b0});
        end
    end
endmodule

// ### tb/servo_ctrl_chk.sv
`timescale 1ns/100ps
module servo_ctrl_chk #(
    parameter TICK_CYCLES = 10,
    parameter BLINK_CYCLES = 4
) (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire psel, // select
    input wire penable, // access phase
    input wire pwrite, // direction
    input wire [7:0] paddr, // address
    input wire [31:0] pwdata, // write data
    input wire [31:0] prdata, // read data
    input wire pready, // ready
    input wire pslverr, // error
    input wire enable_input, // enable pin
    input wire constant_select_input, // select pin
    input wire [9:0] analogue_setpoint_input, // adc word
    input wire phase_short, // short detect
    input wire [15:0] dc_link_level, // dc-link word
    input wire [7:0] stage_temp_c, // temperature
    input wire [2:0] angle_state, // sensor lines
    input wire [15:0] motor_current_mag, // current
    input wire power_stage_on, // stage
    input wire led_red, // led
    input wire signed [31:0] speed_setpoint_out, // speed
    input wire signed [17:0] current_setpoint_out, // current
    input wire [15:0] current_limit_out, // limit
    input wire [13:0] kp_out, // gain
    input wire [15:0] tn_out, // reset time
    input wire save_pulse_out // save
);
    // one domain, so one clock and one reset for all
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_wait: assert property (
        psel && penable && !pready |=> pready)
        else $error("ready missing after one wait state");
    chk_slverr_zero: assert property (
        pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    chk_save_pulse: assert property (
        save_pulse_out |=> !save_pulse_out)
        else $error("save request longer than one cycle");
    // sync chain plus register stage fits inside five cycles
    chk_enable_off: assert property (
        (!enable_input) [*5] |-> !power_stage_on)
        else $error("stage on without enable");
    chk_temp_trip: assert property (
        (stage_temp_c > 8'h55) [*5] |-> !power_stage_on)
        else $error("stage on above temperature limit");
    chk_angle_trip: assert property (
        (angle_state == 3'h0 || angle_state == 3'h7) [*5]
        |-> !power_stage_on)
        else $error("stage on with invalid angle state");
    chk_short_trip: assert property (
        phase_short [*5] |-> !power_stage_on)
        else $error("stage on during phase short");
    chk_off_zero: assert property (
        (!power_stage_on) [*3] |-> speed_setpoint_out == 32'sh0)
        else $error("setpoint not zero with stage off");
    chk_stage_rearm: assert property (
        $rose(power_stage_on) |-> $past(enable_input, 2)
        && stage_temp_c <= 8'h55 && !phase_short)
        else $error("stage returned without cause gone");

    cover property ($rose(power_stage_on));
    cover property ($fell(power_stage_on));
    cover property (save_pulse_out);
endmodule

// ### tb/ctl_partner.sv
`timescale 1ns/100ps
module ctl_partner (
    input wire pclk, // clock
    input wire presetn, // reset, active low
    input wire run_req, // bench wants control enabled
    input wire alt_req, // bench wants constant two
    output reg enable_input, // control enable level
    output reg constant_select_input // 1 picks constant two
);
    // levels move only after an edge; low in reset keeps stage off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_input <= 1'h0;
            constant_select_input <= 1'h0;
        end else begin
            enable_input <= run_req;
            constant_select_input <= alt_req;
        end
    end
endmodule

// ### tb/servo_setpoint_ramp_fault_control_tb.sv
`timescale 1ns/100ps
`include "servo_ctrl_regs.vh"
module servo_setpoint_ramp_fault_control_tb;
    reg pclk = 1'h0; // control clock
    reg presetn = 1'h0; // reset, active low
    reg psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb
    reg [7:0] paddr = 8'h0; // apb address
    reg [31:0] pwdata = 32'h0; // apb write data
    wire [31:0] prdata; // apb read data
    wire pready, pslverr; // apb answer
    reg run_req = 1'h0, alt_req = 1'h0; // partner commands
    wire enable_input, constant_select_input; // partner pins
    reg [9:0] analogue_setpoint_input = 10'h0; // random adc
    reg phase_short = 1'h0; // fault cause
    reg [15:0] dc_link_level = 16'h0, dc_fix = 16'h0; // 0 = random
    reg [7:0] stage_temp_c = 8'h19; // cool stage
    reg [2:0] angle_state = 3'h1; // valid sensor state
    reg [15:0] motor_current_mag = 16'h0; // random, small
    wire power_stage_on, led_red, save_pulse_out; // status
    wire signed [31:0] speed_setpoint_out; // speed
    wire signed [17:0] current_setpoint_out; // current
    wire [15:0] current_limit_out, tn_out; // limit, reset time
    wire [13:0] kp_out; // gain
    integer miscompares = 0, samples_checked = 0, saves = 0;
    integer seed = 48384, n, k;
    reg lit; // led seen lit
    reg [32:0] exp_q[$]; // expected {error, read data}

    servo_setpoint_ramp_fault_control #(.TICK_CYCLES(10),
        .BLINK_CYCLES(4)) i_servo_setpoint_ramp_fault_control (.*);
    ctl_partner i_ctl_partner (.pclk(pclk), .presetn(presetn),
        .run_req(run_req), .alt_req(alt_req),
        .enable_input(enable_input),
        .constant_select_input(constant_select_input));

    always #5 pclk = ~pclk;

    // noise on free inputs; small current keeps the i2t quiet
    always @(posedge pclk) begin
        dc_link_level <= dc_fix != 16'h0 ? dc_fix :
            16'($random(seed)) & 16'h07ff;
        motor_current_mag <= 16'($random(seed)) & 16'h003f;
        analogue_setpoint_input <= 10'($random(seed));
        if (save_pulse_out === 1'h1)
            saves <= saves + 1;
    end

    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    task check(input string nm, input reg [32:0] seen, want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                miscompares = miscompares + 1;
                $display("mismatch %s expected %h seen %h", nm, want, seen);
            end
        end
    endtask

    task expire;
        begin
            check("wait", 33'h1, 33'h0);
            final_report;
        end
    endtask

    // read answers are matched here, oldest note first
    always @(posedge pclk)
        if (psel && penable && pready === 1'h1 && !pwrite)
            check("read", {pslverr, prdata}, exp_q.pop_front());

    // one apb transfer, held until ready, then one idle cycle
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d,
        input reg [32:0] e);
        begin
            if (!w)
                exp_q.push_back(e);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'h1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'h1 && k < 20) begin
                k = k + 1;
                @(posedge pclk);
            end
            if (k == 20)
                expire;
            psel <= 1'h0;
            penable <= 1'h0;
            @(posedge pclk);
        end
    endtask

    task wait_stage(input reg want);
        begin
            k = 0;
            while (power_stage_on !== want && k < 60) begin
                @(posedge pclk);
                k = k + 1;
            end
            if (k == 60)
                expire;
        end
    endtask

    // level 0 = boundary but legal, 1 = fault, 2 = all normal
    task apply(input integer f, lvl);
        begin
            phase_short <= f == 0 && lvl == 1;
            dc_fix <= f != 1 || lvl == 2 ? 16'h0 :
                lvl == 1 ? 16'h0ffd : `RST_OV_LIMIT;
            stage_temp_c <= f != 2 || lvl == 2 ? 8'h19 :
                lvl == 1 ? 8'h56 : `OT_LIMIT_C;
            angle_state <= lvl != 1 ? 3'h1 : f == 3 ? 3'h0 :
                f == 4 ? 3'h7 : 3'h1;
        end
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, `OFS_CTRL, 32'h0, {25'h0, `RST_CTRL});
        apb(1'h0, `OFS_SCALE, 32'h0, {17'h0, `RST_SCALE});
        apb(1'h0, `OFS_DECEL, 32'h0, {17'h0, `RST_ACCEL});
        apb(1'h0, 8'h3c, 32'h0, 33'h100000000);
        $display("test reset values done");
        apb(1'h1, `OFS_CONST1, 32'h4000, 33'h0);
        apb(1'h1, `OFS_CONST2, 32'h2000, 33'h0);
        apb(1'h1, `OFS_CTRL, 32'h09, 33'h0);
        run_req <= 1'h1;
        wait_stage(1'h1);
        repeat (30) @(posedge pclk);
        check("speed", {1'h0, speed_setpoint_out}, 33'h0000249f0);
        alt_req <= 1'h1;
        repeat (6) @(posedge pclk);
        check("speed", {1'h0, speed_setpoint_out}, 33'h0000124f8);
        alt_req <= 1'h0;
        apb(1'h1, `OFS_CTRL, 32'h49, 33'h0);
        repeat (3) @(posedge pclk);
        check("speed", {1'h0, speed_setpoint_out}, 33'h0fffdb610);
        apb(1'h1, `OFS_CTRL, 32'h89, 33'h0);
        apb(1'h0, `OFS_CTRL, 32'h0, 33'h09);
        check("save", {1'h0, saves}, 33'h1);
        $display("test sources done");
        apb(1'h1, `OFS_KP, 32'h270f, 33'h0);
        apb(1'h1, `OFS_KP, 32'h2710, 33'h0);
        apb(1'h1, `OFS_TN, 32'h1234, 33'h0);
        apb(1'h0, `OFS_KP, 32'h0, {19'h0, `KP_MAX});
        check("kp", {19'h0, kp_out}, {19'h0, `KP_MAX});
        check("tn", {17'h0, tn_out}, 33'h1234);
        apb(1'h1, `OFS_CTRL, 32'h08, 33'h0);
        repeat (4) @(posedge pclk);
        check("speed", {1'h0, speed_setpoint_out}, 33'h0);
        // half scale of constant one against rated current 0x400
        check("cur", {15'h0, current_setpoint_out}, 33'h200);
        check("limit", {17'h0, current_limit_out}, {17'h0, `RST_PEAK_I});
        apb(1'h1, `OFS_ACCEL, 32'h5, 33'h0);
        apb(1'h1, `OFS_CTRL, 32'h19, 33'h0);
        repeat (35) @(posedge pclk);
        lit = speed_setpoint_out > 0 && speed_setpoint_out <= 32'sh14;
        check("ramp", {32'h0, lit}, 33'h1);
        // serial source, ramp off: half scale lands at once
        apb(1'h1, `OFS_SERIAL_SP, 32'h4000, 33'h0);
        apb(1'h1, `OFS_CTRL, 32'h05, 33'h0);
        repeat (3) @(posedge pclk);
        check("speed", {1'h0, speed_setpoint_out}, 33'h0000249f0);
        // positioning with ramp off still ramps down slowly
        apb(1'h1, `OFS_CTRL, 32'h06, 33'h0);
        apb(1'h1, `OFS_SERIAL_SP, 32'h2000, 33'h0);
        repeat (30) @(posedge pclk);
        lit = speed_setpoint_out > 32'sd75000 &&
            speed_setpoint_out < 32'sd150000;
        check("ramp", {32'h0, lit}, 33'h1);
        // settle at quarter scale, then a sin2 step back to half
        apb(1'h1, `OFS_CTRL, 32'h05, 33'h0);
        apb(1'h1, `OFS_ACCEL, 32'h8000, 33'h0);
        apb(1'h1, `OFS_CTRL, 32'h25, 33'h0);
        apb(1'h1, `OFS_SERIAL_SP, 32'h4000, 33'h0);
        repeat (12) @(posedge pclk);
        lit = speed_setpoint_out > 32'sd75000 &&
            speed_setpoint_out < 32'sd150000;
        check("sin2", {32'h0, lit}, 33'h1);
        repeat (50) @(posedge pclk);
        check("sin2", {1'h0, speed_setpoint_out}, 33'h0000249f0);
        apb(1'h1, `OFS_CTRL, 32'h09, 33'h0);
        $display("test modes done");
        for (n = 0; n < 5; n = n + 1) begin
            apply(n, 0);
            repeat (8) @(posedge pclk);
            check("stage", {32'h0, power_stage_on}, 33'h1);
            apply(n, 1);
            wait_stage(1'h0);
            lit = 1'h0;
            repeat (40) begin
                @(posedge pclk);
                lit = lit | led_red;
            end
            check("led", {32'h0, lit}, 33'h1);
            apply(n, 2);
            repeat (10) @(posedge pclk);
            check("stage", {32'h0, power_stage_on}, 33'h0);
            run_req <= 1'h0;
            repeat (6) @(posedge pclk);
            run_req <= 1'h1;
            wait_stage(1'h1);
        end
        $display("test faults done");
        final_report;
    end
endmodule

bind servo_setpoint_ramp_fault_control servo_ctrl_chk #(
    .TICK_CYCLES(TICK_CYCLES), .BLINK_CYCLES(BLINK_CYCLES)) i_chk (.*);
